// >>> src/fpdrc_ctrl.v
// power-down, lock readback and reset control of a serial flash
`timescale 1ns/1ps
`default_nettype none
`include "fpdrc_defs.vh"
module fpdrc_ctrl #(
  parameter INTRST_CYC = 16
) (
  input wire clk,
  input wire rstn,
  input wire sck,
  input wire cs_n,
  input wire si,
  input wire por_pulse,
  input wire jedec_rst_pulse,
  input wire hw_rst_n,
  input wire [7:0] status_register_three,
  input wire [7:0] status_register_four,
  input wire [7:0] lock_field,
  input wire op_busy,
  output reg [23:0] lock_addr,
  output reg so,
  output reg so_oe,
  output reg shallow_power_down,
  output reg deepest_power_down,
  output reg dev_reset,
  output reg sram_lost,
  output reg op_abort,
  output reg op_term,
  output reg prog_start,
  output reg erase_start,
  output reg op_refused
);
// =====================================================
// input synchronisers
reg [2:0] sck_s;
reg [1:0] cs_s;
reg [1:0] si_s;
reg [2:0] hw_s;
always @(posedge clk) begin
  if (!rstn) begin
    sck_s <= 3'h0;
    cs_s <= 2'h3;
    si_s <= 2'h0;
    hw_s <= 3'h7;
  end else begin
    sck_s <= {sck_s[1:0], sck};
    cs_s <= {cs_s[0], cs_n};
    si_s <= {si_s[0], si};
    hw_s <= {hw_s[1:0], hw_rst_n};
  end
end
wire sck_rise = sck_s[1] & ~sck_s[2];
wire sck_fall = ~sck_s[1] & sck_s[2];
wire sel = ~cs_s[1];
// =====================================================
// opcode classes
function is_prog;
  input [7:0] op;
  begin
    is_prog = (op == `FPDRC_OP_PP) || (op == `FPDRC_OP_SEQ_A) ||
      (op == `FPDRC_OP_SEQ_B) || (op == `FPDRC_OP_DPP) ||
      (op == `FPDRC_OP_QPP) || (op == `FPDRC_OP_SECPP);
  end
endfunction
function is_erase;
  input [7:0] op;
  begin
    is_erase = (op == `FPDRC_OP_ER4K) || (op == `FPDRC_OP_ER32K) ||
      (op == `FPDRC_OP_ER64K) || (op == `FPDRC_OP_CER_A) ||
      (op == `FPDRC_OP_CER_B);
  end
endfunction
// =====================================================
// state
localparam ST_OP = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_OUT = 3'h2;
localparam ST_DONE = 3'h3;
localparam ST_CHK = 3'h4;
reg [2:0] st_r;
reg [7:0] sh_r;
reg [5:0] cnt_r;
reg [7:0] op_r;
reg [7:0] osh_r;
reg rst_armed_r;
reg rsten_latch_r;
reg [7:0] irst_r;
reg busy_prog_r;
wire op_done = (st_r == ST_OP) && sck_rise && sel && (cnt_r == 6'd7);
wire [7:0] op_now = {sh_r[6:0], si_s[1]};
wire in_pd = shallow_power_down | deepest_power_down;
// enable latched before power-down
// falling pin edge only, so a held pin gives one reset
wire hw_hit = ~hw_s[1] & hw_s[2] & rsten_latch_r;
wire hard_rst = por_pulse | jedec_rst_pulse | hw_hit;
wire sw_rst = op_done && rst_armed_r && (op_now == `FPDRC_OP_RST);
wire abort_rst = hard_rst | (sw_rst & ~deepest_power_down);
always @(posedge clk) begin
  if (!rstn) begin
    st_r <= ST_OP;
    sh_r <= 8'h00;
    cnt_r <= 6'd0;
    op_r <= 8'h00;
    osh_r <= 8'h00;
    lock_addr <= 24'h000000;
    so <= 1'b0;
    so_oe <= 1'b0;
    shallow_power_down <= 1'b0;
    deepest_power_down <= 1'b0;
    dev_reset <= 1'b0;
    sram_lost <= 1'b0;
    op_abort <= 1'b0;
    op_term <= 1'b0;
    prog_start <= 1'b0;
    erase_start <= 1'b0;
    op_refused <= 1'b0;
    rst_armed_r <= 1'b0;
    rsten_latch_r <= 1'b0;
    irst_r <= 8'h00;
    busy_prog_r <= 1'b0;
  end else begin
    op_abort <= 1'b0;
    op_term <= 1'b0;
    prog_start <= 1'b0;
    erase_start <= 1'b0;
    op_refused <= 1'b0;
    sram_lost <= 1'b0;
    dev_reset <= (irst_r != 8'h00);
    if (irst_r != 8'h00)
      irst_r <= irst_r - 8'h01;
    if (!in_pd)
      rsten_latch_r <= status_register_three[`FPDRC_SR3_RSTEN_BIT];
    if (!sel) begin
      st_r <= ST_OP;
      cnt_r <= 6'd0;
      so_oe <= 1'b0;
    end
    if (abort_rst) begin
      op_abort <= op_busy;
      shallow_power_down <= 1'b0;
      deepest_power_down <= 1'b0;
      rst_armed_r <= 1'b0;
      busy_prog_r <= 1'b0;
      irst_r <= INTRST_CYC[7:0];
      dev_reset <= 1'b1;
      st_r <= ST_DONE;
      so_oe <= 1'b0;
    end else if (op_done) begin
      st_r <= ST_DONE;
      op_r <= op_now;
      rst_armed_r <= (op_now == `FPDRC_OP_RST_EN);
      if (in_pd) begin
        // only exit opcodes count, and reset opcodes in shallow power-down
        if (op_now == `FPDRC_OP_WAKE) begin
          shallow_power_down <= 1'b0;
          deepest_power_down <= 1'b0;
          if (deepest_power_down) begin
            irst_r <= INTRST_CYC[7:0];
            dev_reset <= 1'b1;
            sram_lost <= 1'b1;
          end
        end
      end else if (op_now == `FPDRC_OP_PDOWN) begin
        if (status_register_four[`FPDRC_SR4_PDSEL_BIT])
          shallow_power_down <= 1'b1;
        else
          deepest_power_down <= 1'b1;
      end else if (op_now == `FPDRC_OP_PDOWN_DEEP) begin
        deepest_power_down <= 1'b1;
      end else if (op_now == `FPDRC_OP_TERM) begin
        op_term <= op_busy;
      end else if ((op_now == `FPDRC_OP_LOCKRD_A) ||
                   (op_now == `FPDRC_OP_LOCKRD_B) ||
                   is_prog(op_now) || is_erase(op_now)) begin
        // both lock read opcodes same path
        st_r <= ST_ADDR;
        cnt_r <= 6'd0;
      end
    end else if (st_r == ST_CHK) begin
      // lock field judged one cycle after the last address bit lands
      st_r <= ST_DONE;
      if ((op_r == `FPDRC_OP_LOCKRD_A) ||
          (op_r == `FPDRC_OP_LOCKRD_B))
        st_r <= ST_OUT;
      // locked block refuses program and erase
      else if (lock_field[0])
        op_refused <= 1'b1;
      else if (is_prog(op_r)) begin
        prog_start <= 1'b1;
        busy_prog_r <= 1'b1;
      end
      else if (is_erase(op_r))
        erase_start <= 1'b1;
    end else if (sel && sck_rise && (st_r != ST_OUT)) begin
      sh_r <= op_now;
      cnt_r <= cnt_r + 6'd1;
      if (st_r == ST_ADDR) begin
        lock_addr <= {lock_addr[22:0], si_s[1]};
        if (cnt_r == 6'd23) begin
          cnt_r <= 6'd0;
          st_r <= ST_CHK;
        end
      end
    end else if (sel && sck_fall && (st_r == ST_OUT)) begin
      if (cnt_r == 6'd0) begin
        so <= lock_field[7];
        osh_r <= {lock_field[6:0], 1'b0};
      end else begin
        so <= osh_r[7];
        osh_r <= {osh_r[6:0], 1'b0};
      end
      so_oe <= ~in_pd;
      cnt_r <= (cnt_r == 6'd7) ? 6'd0 : cnt_r + 6'd1;
    end
    if (!sel && !op_done)
      sh_r <= 8'h00;
  end
end
endmodule
`default_nettype wire

// >>> src/fpdrc_defs.vh
// constants for the flash power-down and reset control block
// Operation
// - lock query opcodes 3Ch and 3Dh, each with 24-bit address, act identically
// - the 8-bit lock field shifts out on serial output, msb first
// - lock field lsb 1 means locked; program and erase refused there
// - power-down opcode with select bit 1 enters shallow power-down
// - power-down opcode with select bit 0 enters deepest power-down
// - legacy opcode 79h always enters deepest power-down
// - exit opcode leaves shallow power-down to idle, state kept
// - exit opcode in deepest power-down runs internal reset, then idle
// - software reset pair exits shallow power-down, never deepest
// - chip select release alone never ends power-down
// - terminate opcode never ends power-down
// - power-on, pin-sequence and hardware pin resets end power-down
// - hardware reset pin works only when enabled before power-down
// - program opcodes are classed as program operations
// - erase opcodes are classed as erase operations
// - any reset source during program or erase aborts and fully resets
// - terminate during program or erase halts it without reset
`ifndef FPDRC_DEFS_VH
`define FPDRC_DEFS_VH
`define FPDRC_OP_LOCKRD_A 8'h3C
`define FPDRC_OP_LOCKRD_B 8'h3D
`define FPDRC_OP_PDOWN 8'hB9
`define FPDRC_OP_PDOWN_DEEP 8'h79
`define FPDRC_OP_WAKE 8'hAB
`define FPDRC_OP_RST_EN 8'h66
`define FPDRC_OP_RST 8'h99
`define FPDRC_OP_TERM 8'hF0
`define FPDRC_OP_PP 8'h02
`define FPDRC_OP_SEQ_A 8'hAF
`define FPDRC_OP_SEQ_B 8'hAD
`define FPDRC_OP_DPP 8'hA2
`define FPDRC_OP_QPP 8'h32
`define FPDRC_OP_SECPP 8'h9B
`define FPDRC_OP_ER4K 8'h20
`define FPDRC_OP_ER32K 8'h52
`define FPDRC_OP_ER64K 8'hD8
`define FPDRC_OP_CER_A 8'h60
`define FPDRC_OP_CER_B 8'hC7
`define FPDRC_SR4_PDSEL_BIT 7
`define FPDRC_SR3_RSTEN_BIT 7
`define FPDRC_ADDR_BITS 24
`define FPDRC_LOCK_BITS 8
`define FPDRC_INTRST_CYC 8'h10
`endif

// >>> tb/fpdrc_assertions.sv
// assertion checker for the power-down and reset control block
`timescale 1ns/1ps
`default_nettype none
module fpdrc_chk #(
  parameter INTRST_CYC = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic so_oe,
  input wire logic shallow_power_down,
  input wire logic deepest_power_down,
  input wire logic dev_reset,
  input wire logic sram_lost,
  input wire logic op_abort,
  input wire logic op_term,
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic op_refused,
  input wire logic [7:0] lock_field
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] rcnt_r;
  always @(posedge clk) begin
    rcnt_r <= (!rstn || !dev_reset) ? 8'h00 : rcnt_r + 8'h01;
  end
  sequence deep_exit_s; $fell(deepest_power_down); endsequence
  sequence rst_start_s; ##[0:2] $rose(dev_reset); endsequence
  a_pd_no_drive: assert property (shallow_power_down || deepest_power_down
    |-> !so_oe && !prog_start && !erase_start) else $error("active in pd");
  a_one_mode: assert property (!(shallow_power_down && deepest_power_down))
    else $error("both power-down modes");
  a_deep_exit_rst: assert property (deep_exit_s |-> rst_start_s)
    else $error("deep exit without reset");
  a_lost_deep: assert property (sram_lost |-> $past(deepest_power_down))
    else $error("sram loss without deep exit");
  a_rst_len: assert property ($fell(dev_reset) |-> rcnt_r == INTRST_CYC + 1)
    else $error("internal reset length");
  a_abort_reset: assert property (op_abort |-> ##[0:2] dev_reset)
    else $error("abort without reset");
  a_term_no_rst: assert property (op_term |-> !dev_reset [*4])
    else $error("terminate caused reset");
  a_lock_refuse: assert property (op_refused |-> lock_field[0])
    else $error("refused unlocked block");
  a_lock_allow: assert property (prog_start || erase_start
    |-> !lock_field[0] && !op_refused) else $error("started locked block");
endmodule
bind fpdrc_ctrl fpdrc_chk #(.INTRST_CYC(INTRST_CYC)) fpdrc_chk_inst (.*);
`default_nettype wire

// >>> tb/fpdrc_host.sv
// spi host model sending command frames to the control block
`timescale 1ns/1ps
`default_nettype none
module fpdrc_host (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // opcode, then 24-bit address, msb first
  task automatic frame(input logic [7:0] op, input int na,
    input logic [23:0] adr, input int nr, output logic [7:0] rd);
    logic [31:0] w;
    w = {op, adr};
    rd = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 8 + na + nr; i++) begin
      si <= (i < 8 + na) ? w[31 - i] : ~si;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      if (i >= 8 + na) rd = {rd[6:0], (so_oe === 1'b1) ? so : 1'bx};
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
  endtask
endmodule
`default_nettype wire

// >>> tb/fpdrc_tb.sv
// self-checking bench for the power-down and reset control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic por_pulse = 1'b0;
  logic jedec_rst_pulse = 1'b0;
  logic hw_rst_n = 1'b1;
  logic op_busy = 1'b0;
  logic [7:0] status_register_three = 8'h80;
  logic [7:0] status_register_four = 8'h00;
  wire logic sck, cs_n, si, so, so_oe, shallow_power_down, deepest_power_down;
  wire logic dev_reset, sram_lost, op_abort, op_term, prog_start;
  wire logic erase_start, op_refused;
  wire logic [23:0] lock_addr;
  wire logic [7:0] lock_field = lock_addr[7:0] ^ 8'h5A;
  wire logic [4:0] evs = {op_abort, op_term, op_refused, erase_start,
    prog_start};
  logic [3:0] exp_q[$];
  logic [1:0] pd_q = 2'b00;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] pe [0:10] = '{8'h02, 8'hAF, 8'hAD, 8'hA2, 8'h32, 8'h9B,
    8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  logic [23:0] plan [0:26] = '{
    24'hC0F007, 24'hC10008, 24'hC20008, 24'hC30008,
    24'hC0660F, 24'hC09908,
    24'h60B902, 24'h60F00F, 24'h60020F, 24'h60660F, 24'h609900,
    24'h40B901, 24'h40660F, 24'h40990F, 24'h40F00F, 24'h40AB00,
    24'h607901, 24'h60AB00, 24'h60B902, 24'h610000,
    24'h607901, 24'h620000, 24'h40B901, 24'h630000,
    24'h20B902, 24'h23000F, 24'h20AB00};
  always #12.5 clk = ~clk;
  fpdrc_ctrl #(.INTRST_CYC(2)) fpdrc_ctrl_inst (.*);
  fpdrc_host fpdrc_host_inst (.*);
  always @(posedge clk) if (op_abort || op_term) op_busy <= 1'b0;
  function automatic int nad(input logic [7:0] op);
    nad = (op inside {8'h3C, 8'h3D, 8'h02, 8'hAF, 8'hAD, 8'hA2, 8'h32,
      8'h9B, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7}) ? 24 : 0;
  endfunction
  task automatic chk(input logic [3:0] ev);
    logic [3:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hF;
    tests_run++;
    if (e !== ev) begin
      fails++;
      $display("unexpected at %0t: event %h, noted %h", $time, ev, e);
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: noted events not seen", $time);
    end
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic act(input logic [23:0] d);
    logic [7:0] r;
    logic [23:0] a;
    a = $urandom;
    op_busy <= d[23];
    status_register_three <= {d[22], a[6:0]};
    status_register_four <= {d[21], a[13:7]};
    if (d[3:0] != 4'hF) exp_q.push_back(d[3:0]);
    case (d[17:16])
      2'd0: fpdrc_host_inst.frame(d[15:8], nad(d[15:8]), a, 0, r);
      2'd1: por_pulse <= 1'b1;
      2'd2: jedec_rst_pulse <= 1'b1;
      default: hw_rst_n <= 1'b0;
    endcase
    @(posedge clk);
    por_pulse <= 1'b0;
    jedec_rst_pulse <= 1'b0;
    repeat (3) @(posedge clk);
    hw_rst_n <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rstn === 1'b1) begin
      if ({shallow_power_down, deepest_power_down} !== pd_q)
        chk({2'b00, shallow_power_down, deepest_power_down});
      pd_q = {shallow_power_down, deepest_power_down};
      for (int k = 0; k < 5; k++) begin
        if (evs[k])
          chk(4'h4 + 4'(k));
      end
    end
  end
  initial begin
    logic [7:0] r;
    logic [23:0] a;
    void'($urandom(32'hCB8E7C76));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      a = $urandom;
      fpdrc_host_inst.frame(8'h3C + 8'(i), 24, a, 8, r);
      tests_run++;
      if (r !== (a[7:0] ^ 8'h5A)) begin
        fails++;
        $display("unexpected at %0t: lock field %h", $time, r);
      end
    end
    for (int i = 0; i < 11; i++) begin
      a = $urandom;
      a[0] = (i == 0 || i == 6);
      exp_q.push_back(a[0] ? 4'h6 : (i < 6 ? 4'h4 : 4'h5));
      fpdrc_host_inst.frame(pe[i], 24, a, 0, r);
      repeat (20) @(posedge clk);
    end
    for (int i = 0; i < 27; i++) act(plan[i]);
    repeat (20) @(posedge clk);
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    finish_test();
  end
endmodule
`default_nettype wire
